// *** dv/board_model.sv ***
// Board side of the controller: reset pins and two oscillators.
// Assumes the bench raises requests; oscillators run in real time while their run input is high.
`timescale 1ns/1ps

module board_model
#(
    parameter realtime SLOW_HALF = 41.0,
    parameter realtime MAIN_HALF = 33.0
)
(
    // Requests from the bench
    input wire logic por_req,
    input wire logic ext_req,
    input wire logic slow_run,
    input wire logic main_run,
    // Board pins
    output logic power_on_reset_n,
    output logic external_reset_in_n,
    output logic slow_osc_in,
    output logic main_osc_in
);
    // A request holds its pin low for as long as it stands
    assign power_on_reset_n = ~por_req;
    assign external_reset_in_n = ~ext_req;

    initial slow_osc_in = 1'b0;
    initial main_osc_in = 1'b0;

    // A stopped source holds its level, as an external clock run to DC
    always #(SLOW_HALF) if (slow_run) slow_osc_in = ~slow_osc_in;
    always #(MAIN_HALF) if (main_run) main_osc_in = ~main_osc_in;
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the reset and clock source controller.
// Assumes board_model drives the pins; delays are shortened to 5 and 20,
// and the real-time divider to RTC_N so that ticks fit in the run.
`timescale 1ns/1ps

module tb;
    import rst_clk_pkg::*;

    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic por_req = 1'b1;
    logic ext_req = 1'b1;
    logic wdt_req = 1'b0;
    logic soft_req = 1'b0;
    logic pll_locked = 1'b1;
    logic pll_bypass = 1'b0;
    logic main_run = 1'b1;
    logic por_n, ext_n, slow_in, main_in;
    logic slow_out, slow_oe, main_out, main_oe, test_mode;
    reset_out_s resets;
    clock_out_s clocks;
    int bad_count = 0;
    int total_checks = 0;
    localparam int RTC_N = 4;

    always #4 sys_clk = ~sys_clk;

    board_model board (
        .por_req(por_req),
        .ext_req(ext_req),
        .slow_run(1'b1),
        .main_run(main_run),
        .power_on_reset_n(por_n),
        .external_reset_in_n(ext_n),
        .slow_osc_in(slow_in),
        .main_osc_in(main_in)
    );

    rst_clk_ctrl #(
        .UNLOCKED_DELAY(20),
        .LOCKED_DELAY(5),
        .RTC_DIV(RTC_N)
    ) dut (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .power_on_reset_n(por_n),
        .external_reset_in_n(ext_n),
        .wdt_reset_req(wdt_req),
        .soft_reset_req(soft_req),
        .pll_locked(pll_locked),
        .pll_bypass(pll_bypass),
        .slow_osc_in(slow_in),
        .slow_osc_out(slow_out),
        .slow_osc_out_oe(slow_oe),
        .main_osc_in(main_in),
        .main_osc_out(main_out),
        .main_osc_out_oe(main_oe),
        .resets(resets),
        .clocks(clocks),
        .test_mode(test_mode)
    );

    task automatic chk(input string what, input logic seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[FAIL] %s expected %b seen %b", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("Checks %0d, mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Called at the edge where the last source drops
    task automatic rel_chk(input logic lk);
        tick(4);
        #1 chk("sys early", resets.sys_reset_n, 1'b0);
        tick(10);
        #1 chk("sys mid", resets.sys_reset_n, lk);
        tick(31);
        #1 chk("sys late", resets.sys_reset_n, 1'b1);
        chk("rtc late", resets.rtc_reset_n, 1'b1);
    endtask

    task automatic t_power_on;
        tick(6);
        #1 chk("por sys", resets.sys_reset_n, 1'b0);
        chk("por rtc", resets.rtc_reset_n, 1'b0);
        chk("por jtag", resets.jtag_reset_n, 1'b0);
        chk("mode low", test_mode, 1'b0);
        @(posedge sys_clk) ext_req <= 1'b0;
        tick(6);
        #1 chk("mode high", test_mode, 1'b1);
        @(posedge sys_clk) por_req <= 1'b0;
        rel_chk(1'b1);
        chk("jtag out", resets.jtag_reset_n, 1'b1);
        $display("t_power_on done");
    endtask

    task automatic t_ext_pin;
        @(posedge sys_clk) pll_locked <= 1'b0;
        ext_req <= 1'b1;
        tick(5);
        #1 chk("ext sys", resets.sys_reset_n, 1'b0);
        chk("ext rtc", resets.rtc_reset_n, 1'b0);
        chk("ext jtag", resets.jtag_reset_n, 1'b1);
        chk("mode kept", test_mode, 1'b1);
        @(posedge sys_clk) ext_req <= 1'b0;
        rel_chk(1'b0);
        $display("t_ext_pin done");
    endtask

    // Watchdog request first with the PLL unlocked, then a soft reset
    task automatic t_internal;
        for (int k = 0; k < 2; k++)
        begin
            @(posedge sys_clk) pll_locked <= k[0];
            tick(4);
            @(posedge sys_clk);
            wdt_req <= (k == 0);
            soft_req <= (k == 1);
            @(posedge sys_clk);
            wdt_req <= 1'b0;
            soft_req <= 1'b0;
            #1 chk("req sys", resets.sys_reset_n, 1'b0);
            chk("req rtc", resets.rtc_reset_n, 1'b0);
            chk("req jtag", resets.jtag_reset_n, 1'b1);
            rel_chk(k[0]);
        end
        $display("t_internal done");
    endtask

    // Sampling at 8 ns cannot miss a 33 ns oscillator phase
    task automatic count(input int n, output int mr, pr, bt, ub);
        logic m, p, b;
        mr = 0;
        pr = 0;
        bt = 0;
        ub = 0;
        repeat (n)
        begin
            m = main_in;
            p = clocks.pll_ref;
            b = clocks.bypass_clk;
            @(posedge sys_clk);
            #1;
            mr += int'(main_in & ~m);
            pr += int'(clocks.pll_ref & ~p);
            bt += int'(clocks.bypass_clk != b);
            ub += int'(clocks.uart_clk !== {NUM_UARTS{clocks.pll_ref}});
        end
    endtask

    // Ticks and oscillator outputs against the pins over 400 cycles
    task automatic t_rtc;
        int sr, sf, mf, tk, so, mo, ex;
        logic s, m, o, q;
        sr = 0;
        sf = 0;
        mf = 0;
        tk = 0;
        so = 0;
        mo = 0;
        repeat (400)
        begin
            s = slow_in;
            m = main_in;
            o = slow_out;
            q = main_out;
            @(posedge sys_clk);
            #1;
            sr += int'(slow_in & ~s);
            sf += int'(s & ~slow_in);
            mf += int'(m & ~main_in);
            tk += int'(clocks.rtc_tick);
            so += int'(slow_out & ~o);
            mo += int'(main_out & ~q);
        end
        ex = sr / RTC_N;
        chk("rtc ticks", tk >= ex - 1 && tk <= ex + 1, 1'b1);
        chk("rtc seen", tk > 0, 1'b1);
        chk("slow out", so >= sf - 1 && so <= sf + 1, 1'b1);
        chk("main out", mo >= mf - 1 && mo <= mf + 1, 1'b1);
        $display("t_rtc done");
    endtask

    task automatic t_clocks;
        int mr, pr, bt, ub;
        count(80, mr, pr, bt, ub);
        chk("pll ref", pr >= mr - 1 && pr <= mr + 1, 1'b1);
        chk("uart clk", ub == 0, 1'b1);
        chk("main oe", main_oe, 1'b1);
        chk("slow oe", slow_oe, 1'b1);
        @(posedge sys_clk) pll_bypass <= 1'b1;
        tick(8);
        count(80, mr, pr, bt, ub);
        chk("bypass clk", bt >= mr - 1 && bt <= mr + 1, 1'b1);
        chk("main float", main_oe, 1'b0);
        @(posedge sys_clk) main_run <= 1'b0;
        tick(10);
        count(40, mr, pr, bt, ub);
        chk("stopped", bt == 0, 1'b1);
        chk("alive", resets.sys_reset_n, 1'b1);
        $display("t_clocks done");
    endtask

    initial
    begin
        #20us;
        bad_count++;
        $display("[FAIL] run time expected under 20us seen timeout");
        wrap_up();
    end

    initial
    begin
        repeat (5) @(posedge sys_clk);
        resetn <= 1'b1;
        t_power_on();
        t_ext_pin();
        t_internal();
        t_rtc();
        t_clocks();
        wrap_up();
    end
endmodule

// *** verilog/rst_clk_ctrl.sv ***
// Reset generation and clock source control for the chip.
// Assumes oscillator and reset pins are asynchronous and get sampled
// here; watchdog and soft reset requests come from sys_clk logic.
`timescale 1ns/1ps

module rst_clk_ctrl
#(
    parameter int unsigned UNLOCKED_DELAY = rst_clk_pkg::UNLOCKED_CYC,
    parameter int unsigned LOCKED_DELAY = rst_clk_pkg::LOCKED_CYC,
    parameter int unsigned RTC_DIV = rst_clk_pkg::SLOW_DIV,
    parameter int unsigned CNT_W = 16,
    parameter int unsigned DIV_W = 15
)
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic resetn,
    // Board reset pins
    input wire logic power_on_reset_n,
    input wire logic external_reset_in_n,
    // Internal reset requests
    input wire logic wdt_reset_req,
    input wire logic soft_reset_req,
    // PLL control and status
    input wire logic pll_locked,
    input wire logic pll_bypass,
    // Oscillator pins
    input wire logic slow_osc_in,
    output logic slow_osc_out,
    output logic slow_osc_out_oe,
    input wire logic main_osc_in,
    output logic main_osc_out,
    output logic main_osc_out_oe,
    // Generated resets, clocks and mode
    output rst_clk_pkg::reset_out_s resets,
    output rst_clk_pkg::clock_out_s clocks,
    output logic test_mode
);
    import rst_clk_pkg::*;

    logic [1:0] rst_sync_q;
    logic rst_n;

    // Reset release through two flops
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
    assign rst_n = rst_sync_q[1];

    // Pin synchronisers; hist is only used by the edge detectors
    logic [NUM_PINS-1:0] pin_raw;
    logic [NUM_PINS-1:0] meta_q;
    logic [NUM_PINS-1:0] sync_q;
    logic [NUM_PINS-1:0] hist_q;

    always_comb
    begin
        pin_raw = '0;
        pin_raw[PIN_POR] = power_on_reset_n;
        pin_raw[PIN_EXT] = external_reset_in_n;
        pin_raw[PIN_LOCK] = pll_locked;
        pin_raw[PIN_SLOW] = slow_osc_in;
        pin_raw[PIN_MAIN] = main_osc_in;
    end

    // Pins reset to low so reset pins read as asserted until sampled
    for (genvar i = 0; i < NUM_PINS; i++)
    begin : g_sync
        always_ff @(posedge sys_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
                hist_q[i] <= 1'b0;
            end
            else
            begin
                meta_q[i] <= pin_raw[i];
                sync_q[i] <= meta_q[i];
                hist_q[i] <= sync_q[i];
            end
        end
    end

    logic por_s;
    logic ext_s;
    logic lock_s;
    logic slow_rise;
    logic main_rise;
    logic ext_req;
    logic req;

    assign por_s = sync_q[PIN_POR];
    assign ext_s = sync_q[PIN_EXT];
    assign lock_s = sync_q[PIN_LOCK];
    assign slow_rise = sync_q[PIN_SLOW] & ~hist_q[PIN_SLOW];
    assign main_rise = sync_q[PIN_MAIN] & ~hist_q[PIN_MAIN];

    // External pin is a reset only once power-on is released
    assign ext_req = por_s & ~ext_s;
    // Any source holds the sequencer in reset
    assign req = ~por_s | ext_req | wdt_reset_req | soft_reset_req;

    // Reset sequencer
    rst_state_e state_q;
    rst_state_e state_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic sys_rst_n_q;
    logic sys_rst_n_d;
    logic rtc_rst_n_q;
    logic rtc_rst_n_d;
    logic jtag_rst_n_q;
    logic jtag_rst_n_d;
    logic test_mode_q;
    logic test_mode_d;

    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        case (state_q)
            ST_HOLD:
            begin
                if (!req)
                begin
                    state_d = ST_DELAY;
                    // Unlocked PLL needs time to settle first
                    if (lock_s)
                        cnt_d = CNT_W'(LOCKED_DELAY - 1);
                    else
                        cnt_d = CNT_W'(UNLOCKED_DELAY - 1);
                end
            end
            ST_DELAY:
            begin
                if (req)
                    state_d = ST_HOLD;
                else if (cnt_q == '0)
                    state_d = ST_RUN;
                else
                    cnt_d = cnt_q - CNT_W'(1);
            end
            ST_RUN:
            begin
                if (req)
                    state_d = ST_HOLD;
            end
            default:
            begin
                state_d = ST_HOLD;
            end
        endcase
        // System reset released on a sys_clk edge
        sys_rst_n_d = (state_d == ST_RUN);
        // RTC reset follows system assert, releases on a slow edge
        if (!sys_rst_n_d)
            rtc_rst_n_d = RST_ASSERTED;
        else if (slow_rise)
            rtc_rst_n_d = 1'b1;
        else
            rtc_rst_n_d = rtc_rst_n_q;
        // Debug logic only follows power-on
        jtag_rst_n_d = por_s;
        // Test mode tracks the external pin while power-on is low
        test_mode_d = por_s ? test_mode_q : ext_s;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_HOLD;
            cnt_q <= '0;
            sys_rst_n_q <= RST_ASSERTED;
            rtc_rst_n_q <= RST_ASSERTED;
            jtag_rst_n_q <= RST_ASSERTED;
            test_mode_q <= TEST_MODE_RESET;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            sys_rst_n_q <= sys_rst_n_d;
            rtc_rst_n_q <= rtc_rst_n_d;
            jtag_rst_n_q <= jtag_rst_n_d;
            test_mode_q <= test_mode_d;
        end
    end

    // Clock sources
    logic [DIV_W-1:0] div_q;
    logic [DIV_W-1:0] div_d;
    logic tick_q;
    logic tick_d;
    logic main_fwd_q;
    logic main_fwd_d;
    logic byp_q;
    logic byp_d;
    logic slow_out_q;
    logic slow_out_d;
    logic main_out_q;
    logic main_out_d;

    always_comb
    begin
        div_d = div_q;
        tick_d = 1'b0;
        if (!rtc_rst_n_q)
            div_d = '0;
        else if (slow_rise)
        begin
            if (div_q == DIV_W'(RTC_DIV - 1))
            begin
                div_d = '0;
                tick_d = 1'b1;
            end
            else
                div_d = div_q + DIV_W'(1);
        end
        main_fwd_d = sync_q[PIN_MAIN];
        // Only input edges advance the divider, so a stopped input
        // simply freezes it; nothing times out
        byp_d = byp_q;
        if (pll_bypass && main_rise)
            byp_d = ~byp_q;
        slow_out_d = ~sync_q[PIN_SLOW];
        main_out_d = ~sync_q[PIN_MAIN];
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            div_q <= '0;
            tick_q <= 1'b0;
            main_fwd_q <= 1'b0;
            byp_q <= 1'b0;
            slow_out_q <= 1'b0;
            main_out_q <= 1'b0;
        end
        else
        begin
            div_q <= div_d;
            tick_q <= tick_d;
            main_fwd_q <= main_fwd_d;
            byp_q <= byp_d;
            slow_out_q <= slow_out_d;
            main_out_q <= main_out_d;
        end
    end

    // Outputs
    assign resets.sys_reset_n = sys_rst_n_q;
    assign resets.rtc_reset_n = rtc_rst_n_q;
    assign resets.jtag_reset_n = jtag_rst_n_q;
    assign clocks.pll_ref = main_fwd_q;
    assign clocks.uart_clk = {NUM_UARTS{main_fwd_q}};
    assign clocks.bypass_clk = byp_q;
    assign clocks.rtc_tick = tick_q;
    assign test_mode = test_mode_q;
    assign slow_osc_out = slow_out_q;
    assign slow_osc_out_oe = 1'b1;
    assign main_osc_out = main_out_q;
    // External clock in bypass: leave the output pin floating
    assign main_osc_out_oe = ~pll_bypass;

    // Checks
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!rst_n);

    chk_req_sys_reset: assert property (
        req |=> !resets.sys_reset_n)
        else $error("reset source did not assert system reset");
    chk_rtc_with_sys: assert property (
        !sys_rst_n_q |-> !rtc_rst_n_q)
        else $error("rtc reset released while system reset held");
    chk_por_jtag: assert property (
        !por_s |=> !resets.jtag_reset_n && !resets.sys_reset_n)
        else $error("power-on reset missed debug or system reset");
    chk_ext_spares_jtag: assert property (
        por_s && !ext_s |=> resets.jtag_reset_n && !resets.sys_reset_n)
        else $error("external reset touched debug reset");
    chk_test_mode_cap: assert property (
        !por_s |=> test_mode == $past(ext_s))
        else $error("test mode not taken from external pin");
    chk_test_mode_hold: assert property (
        por_s |=> $stable(test_mode))
        else $error("test mode changed after power-on release");
    chk_locked_delay: assert property (
        state_q == ST_HOLD && !req && lock_s
        |=> cnt_q == CNT_W'(LOCKED_DELAY - 1))
        else $error("locked release delay wrong");
    chk_unlocked_delay: assert property (
        state_q == ST_HOLD && !req && !lock_s
        |=> cnt_q == CNT_W'(UNLOCKED_DELAY - 1))
        else $error("unlocked release delay wrong");
    chk_tick_wrap: assert property (
        clocks.rtc_tick |-> $past(div_q) == DIV_W'(RTC_DIV - 1)
        ##1 !clocks.rtc_tick)
        else $error("rtc tick not on divider wrap");
    chk_rtc_release: assert property (
        $rose(rtc_rst_n_q) |-> $past(slow_rise) && sys_rst_n_q)
        else $error("rtc reset released off a slow clock edge");
    chk_bypass_half: assert property (
        pll_bypass && main_rise |=> byp_q != $past(byp_q))
        else $error("bypass clock missed an input edge");
    chk_uart_feed: assert property (
        clocks.pll_ref == $past(sync_q[PIN_MAIN])
        && clocks.uart_clk == {NUM_UARTS{clocks.pll_ref}})
        else $error("uart clocks differ from main oscillator");
    cov_full_release: cover property (
        state_q == ST_DELAY ##1 state_q == ST_RUN);
    cov_rtc_tick: cover property (clocks.rtc_tick);
    cov_test_mode: cover property ($rose(test_mode));
    cov_wdt_reset: cover property (
        sys_rst_n_q && wdt_reset_req ##1 !sys_rst_n_q);

endmodule

// *** verilog/rst_clk_pkg.sv ***
// Constants and carriers for the reset and clock source controller.
// Assumes a single 125 MHz system clock; oscillator pins are sampled.
package rst_clk_pkg;

    // System clock rate
    localparam int unsigned SYS_CLK_MHZ = 125;

    // Release delay after the last reset source drops, PLL locked
    localparam int unsigned LOCKED_DELAY_NS = 1000;
    localparam int unsigned LOCKED_CYC =
        (LOCKED_DELAY_NS * SYS_CLK_MHZ + 999) / 1000;

    // Release delay when the PLL is not locked (relock allowance)
    localparam int unsigned UNLOCKED_DELAY_US = 100;
    localparam int unsigned UNLOCKED_CYC = UNLOCKED_DELAY_US * SYS_CLK_MHZ;

    // Slow oscillator divider down to the real-time tick
    localparam int unsigned SLOW_OSC_HZ = 32768;
    localparam int unsigned RTC_TICK_HZ = 1;
    localparam int unsigned SLOW_DIV = SLOW_OSC_HZ / RTC_TICK_HZ;

    // Main oscillator range and UART count
    localparam int unsigned MAIN_OSC_MIN_MHZ = 14;
    localparam int unsigned MAIN_OSC_MAX_MHZ = 20;
    localparam int unsigned NUM_UARTS = 3;

    // Positions of the sampled pins in the synchroniser vector
    localparam int unsigned NUM_PINS = 5;
    localparam int unsigned PIN_POR = 0;
    localparam int unsigned PIN_EXT = 1;
    localparam int unsigned PIN_LOCK = 2;
    localparam int unsigned PIN_SLOW = 3;
    localparam int unsigned PIN_MAIN = 4;

    // Reset values
    localparam logic RST_ASSERTED = 1'b0;
    localparam logic TEST_MODE_RESET = 1'b0;

    typedef enum logic [1:0] {
        ST_HOLD,
        ST_DELAY,
        ST_RUN
    } rst_state_e;

    typedef struct packed {
        logic sys_reset_n;
        logic rtc_reset_n;
        logic jtag_reset_n;
    } reset_out_s;

    typedef struct packed {
        logic pll_ref;
        logic [NUM_UARTS-1:0] uart_clk;
        logic bypass_clk;
        logic rtc_tick;
    } clock_out_s;

endpackage
